// ===== rtl/asr_pkg.sv
// Shared constants of the amplifier status register bank.
package asr_pkg;

	// Register map, 8-bit register addresses.
	localparam logic [7:0] ADDR_ID        = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h01;
	localparam logic [7:0] ADDR_EVENTS    = 8'h02;
	localparam logic [7:0] ADDR_MASK      = 8'h03;
	localparam logic [7:0] ADDR_CTRL_LAST = 8'h0A;
	localparam logic [7:0] ADDR_DEBUG     = 8'h20;
	localparam logic [7:0] ADDR_FIFO_CFG  = 8'h21;
	localparam logic [7:0] ADDR_PORT_STAT = 8'h22;
	localparam logic [7:0] ADDR_CAPT_CNT  = 8'h23;
	localparam logic [7:0] ADDR_MEM_PTR   = 8'h40;
	localparam logic [7:0] ADDR_WDOG      = 8'h42;
	localparam logic [7:0] ADDR_BOOST     = 8'h61;

	// Number of read/write configuration registers and their slot numbers.
	localparam int         NUM_CFG        = 14;
	localparam logic [4:0] SLOT_DEBUG     = 5'h08;
	localparam logic [4:0] SLOT_MEM_PTR   = 5'h0A;
	localparam logic [4:0] SLOT_BOOST     = 5'h0D;
	localparam logic [4:0] SLOT_NONE      = 5'h1F;

	// Reset value of every configuration register and the soft reset key.
	localparam logic [15:0] CFG_RESET     = 16'h0000;
	localparam logic [15:0] SOFT_RST_KEY  = 16'h55AA;

	// Bus address: five fixed upper bits, two strap bits below.
	localparam logic [4:0] DEV_ADDR_HI    = 5'h0D;

	// Status word bit positions.
	localparam int BIT_SUPPLY_LOW = 14;
	localparam int BIT_ADAPTIVE   = 13;
	localparam int BIT_ACK_PEND   = 12;
	localparam int BIT_BOOST_OC   = 11;
	localparam int BIT_RSVD_HI    = 15;
	localparam int BIT_RSVD_LO    = 10;
	localparam int BIT_SOFTSTART  = 9;
	localparam int BIT_SWITCHING  = 8;
	localparam int BIT_CLIPPING   = 7;
	localparam int BIT_WATCHDOG   = 6;
	localparam int BIT_REF_MISS   = 5;
	localparam int BIT_CLK_STABLE = 4;
	localparam int BIT_AMP_OC     = 3;
	localparam int BIT_TEMP_WARN  = 2;
	localparam int BIT_TEMP_HIGH  = 1;
	localparam int BIT_LOCKED     = 0;

	// Serial slave states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DEVADR = 3'b001,
		ST_REGADR = 3'b010,
		ST_WRITE  = 3'b011,
		ST_READ   = 3'b100
	} asr_state_t;

endpackage : asr_pkg

// ===== rtl/asr_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1 - ID register reads the fixed chip code.
// RQ2 - Writing 55AA to ID resets configuration.
// RQ3 - Bit 14 undervoltage with 2.5/2.6V hysteresis.
// RQ4 - Bit 13 shows adaptive boost active.
// RQ5 - Bit 12 set when any ack pending.
// RQ6 - Bit 11 shows boost over-current.
// RQ7 - Bit 9 shows boost soft start finished.
// RQ8 - Bit 8 shows output stage switching.
// RQ9 - Bit 7 shows amplifier clipping.
// RQ10 - Bit 6 watchdog fired, device restarts.
// RQ11 - Bit 5 shows reference clock missing.
// RQ12 - Bit 4 is locked and not idle.
// RQ13 - Bit 3 shows amplifier over-current.
// RQ14 - Bit 2 junction above 150 C.
// RQ15 - Bit 1 junction above 160 C.
// RQ16 - Bit 0 shows loop locked.
// RQ17 - Reserved bits zero, read-only writes ignored.
// RQ18 - Event flags mirror status, clear on read.
// RQ19 - Host sends register address before data.
// RQ20 - 16-bit words high first, address increments.
module asr_reg_bank #(
	parameter logic [15:0] CHIP_ID = 16'hA5C3, // Arbitrary value.
	parameter int          ACK_W   = 8
) (
	// Clock and reset.
	input  wire logic                           clock_i,
	input  wire logic                           rst_i,
	// Serial register port, open-drain data.
	input  wire logic                           scl_i,
	input  wire logic                           sda_i,
	output var  logic                           sda_o,
	output var  logic                           sda_oe_o,
	input  wire logic [1:0]                     addr_sel_i,
	// Condition inputs from the analog and processing blocks.
	input  wire logic                           supply_below_low_i,
	input  wire logic                           supply_above_high_i,
	input  wire logic                           adaptive_boost_state_i,
	input  wire logic [ACK_W-1:0]               processor_ack_req_i,
	input  wire logic                           boost_overcurrent_flag_i,
	input  wire logic                           boost_softstart_done_i,
	input  wire logic                           switching_i,
	input  wire logic                           clipping_flag_i,
	input  wire logic                           processor_watchdog_fired_i,
	input  wire logic                           ref_clock_missing_i,
	input  wire logic                           undefined_idle_cond_i,
	input  wire logic                           amp_overcurrent_flag_i,
	input  wire logic                           temp_warn_flag_i,
	input  wire logic                           temp_high_flag_i,
	input  wire logic                           loop_locked_flag_i,
	input  wire logic [15:0]                    audio_port_state_i,
	input  wire logic [15:0]                    audio_capture_counts_i,
	// Configuration and control outputs.
	output var  logic [asr_pkg::NUM_CFG*16-1:0] config_o,
	output var  logic                           soft_reset_o,
	output var  logic                           restart_req_o
);

	localparam int NRAW = ACK_W + 46;

	asr_pkg::asr_state_t state;
	logic [2:0]  scl_sync;
	logic [2:0]  sda_sync;
	logic        scl_rise;
	logic        scl_fall;
	logic        i2c_start;
	logic        i2c_stop;
	logic [3:0]  bit_cnt;
	logic [7:0]  rx_shift;
	logic [7:0]  tx_shift;
	logic [7:0]  reg_ptr;
	logic [7:0]  hi_byte;
	logic [15:0] tx_word;
	logic        byte_hi;
	logic        fetch_next;
	logic        wr_stb;
	logic [7:0]  wr_addr;
	logic [15:0] wr_data;
	logic        rd_clr;
	logic [15:0] rd_clr_mask;
	logic [15:0] fetch_word;
	logic        dev_match;
	logic [NRAW-1:0] raw_vec;
	logic [NRAW-1:0] stat_meta;
	logic [NRAW-1:0] stat_sync;
	logic        supply_low_flag;
	logic [15:0] system_status;
	logic [15:0] status_prev;
	logic [15:0] system_event_flags;
	logic        wd_prev;

	// Maps a register address to its configuration slot, or SLOT_NONE.
	function automatic logic [4:0] cfg_slot(input logic [7:0] a);
		logic [4:0] s;
		s = asr_pkg::SLOT_NONE;
		if (a >= asr_pkg::ADDR_MASK && a <= asr_pkg::ADDR_CTRL_LAST) begin
			s = 5'(a - asr_pkg::ADDR_MASK);
		end else if (a == asr_pkg::ADDR_DEBUG || a == asr_pkg::ADDR_FIFO_CFG) begin
			s = 5'(asr_pkg::SLOT_DEBUG + 5'(a - asr_pkg::ADDR_DEBUG));
		end else if (a >= asr_pkg::ADDR_MEM_PTR && a <= asr_pkg::ADDR_WDOG) begin
			s = 5'(asr_pkg::SLOT_MEM_PTR + 5'(a - asr_pkg::ADDR_MEM_PTR));
		end else if (a == asr_pkg::ADDR_BOOST) begin
			s = asr_pkg::SLOT_BOOST;
		end
		return s;
	endfunction : cfg_slot

	// Read value of any address; unmapped addresses read as zero.
	function automatic logic [15:0] read_reg(input logic [7:0] a);
		logic [15:0] v;
		logic [4:0]  s;
		v = 16'h0000;
		s = cfg_slot(a);
		if (a == asr_pkg::ADDR_ID) begin
			v = CHIP_ID; // [RQ1]
		end else if (a == asr_pkg::ADDR_STATUS) begin
			v = system_status;
		end else if (a == asr_pkg::ADDR_EVENTS) begin
			v = system_event_flags;
		end else if (a == asr_pkg::ADDR_PORT_STAT) begin
			v = stat_sync[31:16];
		end else if (a == asr_pkg::ADDR_CAPT_CNT) begin
			v = stat_sync[15:0];
		end else if (s != asr_pkg::SLOT_NONE) begin
			v = config_o[s*16 +: 16];
		end
		return v;
	endfunction : read_reg

	// Serial lines are asynchronous; the third stage only serves edge detection.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_i};
			sda_sync <= {sda_sync[1:0], sda_i};
		end
	end

	// Bus events decoded from the synchronised lines.
	assign scl_rise  = scl_sync[1] & ~scl_sync[2];
	assign scl_fall  = ~scl_sync[1] & scl_sync[2];
	assign i2c_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	assign i2c_stop  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
	assign dev_match = rx_shift[7:1] == {asr_pkg::DEV_ADDR_HI, addr_sel_i};

	// Word sent next in a read burst: the following register once acknowledged.
	assign fetch_word = fetch_next ? read_reg(8'(reg_ptr + 8'h01)) : tx_word; // [RQ20]

	// Serial slave sequencer: address phase, register pointer, data words.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state       <= asr_pkg::ST_IDLE;
			bit_cnt     <= 4'h0;
			rx_shift    <= 8'h00;
			tx_shift    <= 8'h00;
			reg_ptr     <= 8'h00;
			hi_byte     <= 8'h00;
			tx_word     <= 16'h0000;
			byte_hi     <= 1'b1;
			fetch_next  <= 1'b0;
			wr_stb      <= 1'b0;
			wr_addr     <= 8'h00;
			wr_data     <= 16'h0000;
			rd_clr      <= 1'b0;
			rd_clr_mask <= 16'h0000;
			sda_o       <= 1'b0;
			sda_oe_o    <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_clr <= 1'b0;
			if (i2c_start) begin
				// The clock fall that closes the start condition wraps this count to zero.
				state    <= asr_pkg::ST_DEVADR;
				bit_cnt  <= 4'hF;
				sda_oe_o <= 1'b0;
			end else if (i2c_stop) begin
				state    <= asr_pkg::ST_IDLE;
				sda_oe_o <= 1'b0;
			end else if (scl_rise && state != asr_pkg::ST_IDLE) begin
				if (bit_cnt != 4'h8) begin
					rx_shift <= {rx_shift[6:0], sda_sync[1]};
				end else if (state == asr_pkg::ST_READ && sda_sync[1]) begin
					// A missing acknowledge ends the read; wait for stop.
					state <= asr_pkg::ST_IDLE;
				end
			end else if (scl_fall && state != asr_pkg::ST_IDLE) begin
				if (bit_cnt == 4'h7) begin
					bit_cnt <= 4'h8;
					unique case (state)
						asr_pkg::ST_DEVADR: begin
							if (dev_match) begin
								sda_oe_o <= 1'b1;
								byte_hi  <= 1'b1;
								if (rx_shift[0]) begin
									state       <= asr_pkg::ST_READ;
									fetch_next  <= 1'b0;
									tx_word     <= read_reg(reg_ptr); // [RQ1]
									rd_clr      <= reg_ptr == asr_pkg::ADDR_EVENTS; // [RQ18]
									rd_clr_mask <= system_event_flags;
								end else begin
									state <= asr_pkg::ST_REGADR; // [RQ19]
								end
							end else begin
								state <= asr_pkg::ST_IDLE;
							end
						end
						asr_pkg::ST_REGADR: begin
							reg_ptr  <= rx_shift; // [RQ19]
							state    <= asr_pkg::ST_WRITE;
							byte_hi  <= 1'b1;
							sda_oe_o <= 1'b1;
						end
						asr_pkg::ST_WRITE: begin
							sda_oe_o <= 1'b1;
							if (byte_hi) begin
								hi_byte <= rx_shift; // [RQ20]
								byte_hi <= 1'b0;
							end else begin
								wr_stb  <= 1'b1;
								wr_addr <= reg_ptr;
								wr_data <= {hi_byte, rx_shift};
								reg_ptr <= 8'(reg_ptr + 8'h01); // [RQ20]
								byte_hi <= 1'b1;
							end
						end
						asr_pkg::ST_READ: begin
							// Release the line so the host can acknowledge.
							sda_oe_o <= 1'b0;
						end
						default: begin
							state <= asr_pkg::ST_IDLE;
						end
					endcase
				end else if (bit_cnt == 4'h8) begin
					bit_cnt  <= 4'h0;
					sda_oe_o <= 1'b0;
					if (state == asr_pkg::ST_READ) begin
						if (byte_hi) begin
							tx_shift <= fetch_word[15:8]; // [RQ20]
							sda_oe_o <= ~fetch_word[15];
							tx_word  <= fetch_word;
							byte_hi  <= 1'b0;
							if (fetch_next) begin
								reg_ptr     <= 8'(reg_ptr + 8'h01);
								rd_clr      <= 8'(reg_ptr + 8'h01) == asr_pkg::ADDR_EVENTS; // [RQ18]
								rd_clr_mask <= fetch_word;
							end
						end else begin
							tx_shift   <= tx_word[7:0];
							sda_oe_o   <= ~tx_word[7];
							byte_hi    <= 1'b1;
							fetch_next <= 1'b1;
						end
					end
				end else begin
					bit_cnt <= 4'(bit_cnt + 4'h1);
					if (state == asr_pkg::ST_READ) begin
						tx_shift <= {tx_shift[6:0], 1'b0};
						sda_oe_o <= ~tx_shift[6];
					end
				end
			end
		end
	end

	// Configuration registers; the soft reset key returns all of them to reset.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			config_o     <= {asr_pkg::NUM_CFG{asr_pkg::CFG_RESET}};
			soft_reset_o <= 1'b0;
		end else begin
			soft_reset_o <= 1'b0;
			if (wr_stb) begin
				if (wr_addr == asr_pkg::ADDR_ID && wr_data == asr_pkg::SOFT_RST_KEY) begin
					config_o     <= {asr_pkg::NUM_CFG{asr_pkg::CFG_RESET}}; // [RQ2]
					soft_reset_o <= 1'b1;
				end else if (cfg_slot(wr_addr) != asr_pkg::SLOT_NONE) begin
					// Status, event and other read-only addresses have no slot and never reach here.
					config_o[cfg_slot(wr_addr)*16 +: 16] <= wr_data; // [RQ17]
				end
			end
		end
	end

	// All condition inputs come from other domains and pass two flip-flops.
	assign raw_vec = {supply_below_low_i, supply_above_high_i, adaptive_boost_state_i,
		processor_ack_req_i, boost_overcurrent_flag_i, boost_softstart_done_i, switching_i,
		clipping_flag_i, processor_watchdog_fired_i, ref_clock_missing_i, undefined_idle_cond_i,
		amp_overcurrent_flag_i, temp_warn_flag_i, temp_high_flag_i, loop_locked_flag_i,
		audio_port_state_i, audio_capture_counts_i};

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			stat_meta <= '0;
			stat_sync <= '0;
		end else begin
			stat_meta <= raw_vec;
			stat_sync <= stat_meta;
		end
	end

	// Undervoltage holds between the two comparator levels, giving hysteresis.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			supply_low_flag <= 1'b0;
		end else if (stat_sync[NRAW-1]) begin
			supply_low_flag <= 1'b1; // [RQ3]
		end else if (stat_sync[NRAW-2]) begin
			supply_low_flag <= 1'b0; // [RQ3]
		end
	end

	// Status word assembly; reserved bits are constant zero.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			system_status <= 16'h0000;
		end else begin
			system_status[asr_pkg::BIT_RSVD_HI]    <= 1'b0; // [RQ17]
			system_status[asr_pkg::BIT_SUPPLY_LOW] <= supply_low_flag; // [RQ3]
			system_status[asr_pkg::BIT_ADAPTIVE]   <= stat_sync[NRAW-3]; // [RQ4]
			system_status[asr_pkg::BIT_ACK_PEND]   <= |stat_sync[NRAW-4 -: ACK_W]; // [RQ5]
			system_status[asr_pkg::BIT_BOOST_OC]   <= stat_sync[42]; // [RQ6]
			system_status[asr_pkg::BIT_RSVD_LO]    <= 1'b0; // [RQ17]
			system_status[asr_pkg::BIT_SOFTSTART]  <= stat_sync[41]; // [RQ7]
			system_status[asr_pkg::BIT_SWITCHING]  <= stat_sync[40]; // [RQ8]
			system_status[asr_pkg::BIT_CLIPPING]   <= stat_sync[39]; // [RQ9]
			system_status[asr_pkg::BIT_WATCHDOG]   <= stat_sync[38]; // [RQ10]
			system_status[asr_pkg::BIT_REF_MISS]   <= stat_sync[37]; // [RQ11]
			system_status[asr_pkg::BIT_CLK_STABLE] <= stat_sync[32] & ~stat_sync[36]; // [RQ12]
			system_status[asr_pkg::BIT_AMP_OC]     <= stat_sync[35]; // [RQ13]
			system_status[asr_pkg::BIT_TEMP_WARN]  <= stat_sync[34]; // [RQ14]
			system_status[asr_pkg::BIT_TEMP_HIGH]  <= stat_sync[33]; // [RQ15]
			system_status[asr_pkg::BIT_LOCKED]     <= stat_sync[32]; // [RQ16]
		end
	end

	// Event flags latch rising status bits; a new event wins over a read clear.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			status_prev        <= 16'h0000;
			system_event_flags <= 16'h0000;
		end else begin
			status_prev        <= system_status;
			system_event_flags <= (system_event_flags & ~(rd_clr ? rd_clr_mask : 16'h0000))
				| (system_status & ~status_prev); // [RQ18]
		end
	end

	// A fired watchdog requests a restart of the device, one pulse per event.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wd_prev       <= 1'b0;
			restart_req_o <= 1'b0;
		end else begin
			wd_prev       <= system_status[asr_pkg::BIT_WATCHDOG];
			restart_req_o <= system_status[asr_pkg::BIT_WATCHDOG] & ~wd_prev; // [RQ10]
		end
	end

	// Checks on the documented behaviour.
	sequence s_low_byte_commit;
		scl_fall && !i2c_start && !i2c_stop && state == asr_pkg::ST_WRITE && bit_cnt == 4'h7 && !byte_hi;
	endsequence

	sequence s_key_write;
		wr_stb && wr_addr == asr_pkg::ADDR_ID && wr_data == asr_pkg::SOFT_RST_KEY;
	endsequence

	a_status_reserved: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ17]
		system_status[asr_pkg::BIT_RSVD_HI] == 1'b0 && system_status[asr_pkg::BIT_RSVD_LO] == 1'b0)
		else $error("Reserved status bit set.");

	a_soft_reset_cfg: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ2]
		s_key_write |=> config_o == {asr_pkg::NUM_CFG{asr_pkg::CFG_RESET}} && soft_reset_o)
		else $error("Soft reset key did not clear configuration.");

	a_ro_write_kept: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ17]
		wr_stb && (wr_addr == asr_pkg::ADDR_STATUS || wr_addr == asr_pkg::ADDR_EVENTS) |=> $stable(config_o))
		else $error("Write to read-only register changed configuration.");

	a_ptr_increment: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ20]
		s_low_byte_commit |=> wr_stb && reg_ptr == 8'($past(reg_ptr) + 8'h01) && wr_addr == $past(reg_ptr))
		else $error("Register pointer did not advance after a word.");

	a_id_read_value: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ1]
		scl_fall && !i2c_start && !i2c_stop && state == asr_pkg::ST_DEVADR && bit_cnt == 4'h7
		&& dev_match && rx_shift[0] && reg_ptr == asr_pkg::ADDR_ID |=> tx_word == CHIP_ID)
		else $error("Identification read returned a wrong code.");

	a_undervolt_hyst: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ3]
		stat_sync[NRAW-1] |=> ##1 system_status[asr_pkg::BIT_SUPPLY_LOW])
		else $error("Undervoltage bit not set below the low level.");

	a_clock_stable: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ12]
		system_status[asr_pkg::BIT_CLK_STABLE] |-> system_status[asr_pkg::BIT_LOCKED])
		else $error("Clocks stable reported while the loop is unlocked.");

	a_ack_pending: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ5]
		(|stat_sync[NRAW-4 -: ACK_W]) |=> system_status[asr_pkg::BIT_ACK_PEND])
		else $error("Ack pending bit missing while a request is set.");

	a_event_capture: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ18]
		$rose(system_status[asr_pkg::BIT_CLIPPING]) |=> system_event_flags[asr_pkg::BIT_CLIPPING])
		else $error("Rising status bit did not set its event flag.");

	a_clip_follow: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ9]
		stat_sync[39] ##1 stat_sync[39] |=> system_status[asr_pkg::BIT_CLIPPING])
		else $error("Clipping status did not follow its input.");

endmodule : asr_reg_bank

`default_nettype wire

// ===== tb/asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural bus host; every pin change lands on a falling clock edge.
module asr_host_model (
	// Clock and wire level.
	input  wire logic       clock_i,
	input  wire logic       sda_i,
	input  wire logic [1:0] sel_i,
	// Host drive.
	output var  logic       scl_o,
	output var  logic       sda_pull_o
);
	int nacks = 0;

	// Both lines start released, so the pull-up holds them high.
	initial begin
		scl_o      = 1'b1;
		sda_pull_o = 1'b0;
	end

	// Half a bit lasts eight clocks, twice the minimum, so the slave synchroniser keeps up.
	task automatic hc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : hc

	// Data moves two clocks after the clock falls, never with it, to avoid a false start or stop.
	task automatic start();
		hc(2);
		sda_pull_o = 1'b0;
		hc(6);
		scl_o = 1'b1;
		hc(8);
		sda_pull_o = 1'b1;
		hc(8);
		scl_o = 1'b0;
	endtask : start

	// Ends the transfer and leaves the bus idle.
	task automatic stop();
		hc(2);
		sda_pull_o = 1'b1;
		hc(6);
		scl_o = 1'b1;
		hc(8);
		sda_pull_o = 1'b0;
		hc(8);
	endtask : stop

	// One bit sent by the host.
	task automatic wbit(input logic b);
		hc(2);
		sda_pull_o = ~b;
		hc(6);
		scl_o = 1'b1;
		hc(8);
		scl_o = 1'b0;
	endtask : wbit

	// One bit read from the wire in the middle of the high phase.
	task automatic rbit(output logic b);
		hc(2);
		sda_pull_o = 1'b0;
		hc(6);
		scl_o = 1'b1;
		hc(4);
		b = sda_i;
		hc(4);
		scl_o = 1'b0;
	endtask : rbit

	// Byte out, most significant bit first, then the slave acknowledge.
	task automatic wbyte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			wbit(d[i]);
		end
		rbit(a);
		if (a !== 1'b0) begin
			nacks++;
		end
	endtask : wbyte

	// Byte in; a high acknowledge bit ends the read.
	task automatic rbyte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			rbit(d[i]);
		end
		wbit(last);
	endtask : rbyte

	// Writes n words from d, the last word in the lower half.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
		start();
		wbyte({asr_pkg::DEV_ADDR_HI, sel_i, 1'b0});
		wbyte(a);
		for (int k = 0; k < n; k++) begin
			wbyte(d[16*(n-1-k)+8 +: 8]);
			wbyte(d[16*(n-1-k) +: 8]);
		end
		stop();
	endtask : wr

	// Reads n words through a repeated start; earlier words end up in the upper half.
	task automatic rd(input logic [7:0] a, input int n, output logic [31:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		q = 32'h0000_0000;
		start();
		wbyte({asr_pkg::DEV_ADDR_HI, sel_i, 1'b0});
		wbyte(a);
		start();
		wbyte({asr_pkg::DEV_ADDR_HI, sel_i, 1'b1});
		for (int k = 0; k < n; k++) begin
			rbyte(1'b0, hi);
			rbyte(k == n - 1, lo);
			q = {q[15:0], hi, lo};
		end
		stop();
	endtask : rd
endmodule : asr_host_model

`default_nettype wire

// ===== tb/test_asr_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module test_asr_reg_bank;
	localparam logic [15:0] ID = 16'h3C5A; // Arbitrary value.
	logic         clock_i = 1'b0;
	logic         rst_i   = 1'b1;
	logic [15:0]  cond    = 16'h8000;
	logic         scl;
	logic         sda_pull;
	logic         sda_oe;
	logic         sda_o;
	logic [223:0] cfg;
	logic         soft_rst;
	logic         restart;
	logic [31:0]  q;
	int           n_errors    = 0;
	int           comparisons = 0;
	int           n_restart   = 0;
	int           n_soft      = 0;
	int           bits[13]    = '{14, 13, 12, 11, 9, 8, 7, 6, 5, 3, 2, 1, 0};
	wire          sda_w;

	// Open-drain wire with a pull-up: low whenever either side pulls.
	assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

	// Clock at 25 MHz.
	initial begin
		forever #20 clock_i = ~clock_i;
	end

	// Pulses are counted on the falling edge, well away from the updates.
	always @(negedge clock_i) begin
		if (restart) n_restart++;
		if (soft_rst) n_soft++;
	end

	asr_host_model u_host (.clock_i(clock_i), .sda_i(sda_w), .sel_i(2'b10), .scl_o(scl), .sda_pull_o(sda_pull));

	asr_reg_bank #(.CHIP_ID(ID)) u_dut (
		.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.addr_sel_i(2'b10), .supply_below_low_i(cond[14]), .supply_above_high_i(cond[15]),
		.adaptive_boost_state_i(cond[13]), .processor_ack_req_i({7'h00, cond[12]}),
		.boost_overcurrent_flag_i(cond[11]), .boost_softstart_done_i(cond[9]), .switching_i(cond[8]),
		.clipping_flag_i(cond[7]), .processor_watchdog_fired_i(cond[6]), .ref_clock_missing_i(cond[5]),
		.undefined_idle_cond_i(cond[10]), .amp_overcurrent_flag_i(cond[3]), .temp_warn_flag_i(cond[2]),
		.temp_high_flag_i(cond[1]), .loop_locked_flag_i(cond[0]), .audio_port_state_i(16'h1357),
		.audio_capture_counts_i(16'h2468), .config_o(cfg), .soft_reset_o(soft_rst), .restart_req_o(restart));

	// Conditions change at a falling edge and are given time to cross the synchroniser.
	task automatic setc(input logic [15:0] v);
		@(negedge clock_i);
		cond = v;
		repeat (4) @(negedge clock_i);
	endtask : setc

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	// A full run needs about 20000 clocks; three times that means something hung.
	initial begin
		repeat (60000) @(posedge clock_i);
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (16) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clock_i);
		u_host.rd(8'h00, 1, q);
		`CHK("ident", ID, q[15:0])
		u_host.rd(8'h30, 1, q);
		`CHK("unmapped", 16'h0000, q[15:0])
		u_host.rd(asr_pkg::ADDR_PORT_STAT, 2, q);
		`CHK("port words", 32'h1357_2468, q)
		done("ident");
		// Each condition alone except the idle input, with the supply above the upper threshold unless it is the one tested.
		foreach (bits[i]) begin
			setc(bits[i] == 14 ? 16'h4000 : (16'h8000 | (16'h0001 << bits[i])));
			u_host.rd(asr_pkg::ADDR_STATUS, 1, q);
			`CHK("status", (16'h0001 << bits[i]) | (bits[i] == 0 ? 16'h0010 : 16'h0000), q[15:0])
		end
		`CHK("restart", 1, n_restart)
		u_host.rd(asr_pkg::ADDR_EVENTS, 1, q);
		`CHK("events", 16'h7BFF, q[15:0])
		u_host.rd(asr_pkg::ADDR_EVENTS, 1, q);
		`CHK("events cleared", 16'h0000, q[15:0])
		done("status");
		// Between the thresholds the undervoltage flag keeps its last value.
		setc(16'h4000);
		setc(16'h0401);
		u_host.rd(asr_pkg::ADDR_STATUS, 1, q);
		`CHK("hold idle", 16'h4001, q[15:0])
		u_host.wr(asr_pkg::ADDR_STATUS, 32'h0000_FFFF, 1);
		u_host.rd(asr_pkg::ADDR_STATUS, 1, q);
		`CHK("read only", 16'h4001, q[15:0])
		setc(16'h8000);
		done("hysteresis");
		// Two words in one transfer land in consecutive registers.
		u_host.wr(asr_pkg::ADDR_MASK, 32'h1234_5678, 2);
		`CHK("cfg pair", 32'h5678_1234, cfg[31:0])
		u_host.rd(asr_pkg::ADDR_MASK, 2, q);
		`CHK("read pair", 32'h1234_5678, q)
		u_host.wr(8'h00, 32'h0000_1111, 1);
		`CHK("no key", 32'h5678_1234, cfg[31:0])
		u_host.wr(8'h00, {16'h0000, asr_pkg::SOFT_RST_KEY}, 1);
		`CHK("soft reset", {asr_pkg::NUM_CFG{asr_pkg::CFG_RESET}}, cfg)
		`CHK("soft pulses", 1, n_soft)
		`CHK("nacks", 0, u_host.nacks)
		done("config");
		wrap_up();
	end
endmodule : test_asr_reg_bank

`default_nettype wire
